// ==== logic/tsh_host.sv ====
// Host controller for a three-wire serial temperature sensor
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE1: Host drives on falling, samples on rising
// RULE2: Select frames transfer; high 160 ns between
// RULE3: Plain read is sixteen clocks
// RULE4: Combined transfer: sixteen out, sixteen in
// RULE5: Sensor releases data while select high
// RULE6: Never lower select during clock rise
// RULE7: First bit valid at select fall
// RULE8: Host may end read early
// RULE9: Conversion survives a read in progress
// RULE10: Read returns last finished conversion
// RULE11: Select low at most 32 clocks; the identification frame holds it low for 64
// RULE12: Last eight received bits form command
// RULE13: All ones shutdown, all zeros convert
// RULE14: Host sends only 00 or FF
// RULE15: Power-up mode is continuous conversion
// RULE16: Wait 228 ms for valid temperature
// RULE17: Temperature is 14-bit two's complement, upper
// RULE18: Two lowest word bits read ones
// RULE19: Word sent MSB first
// RULE20: Serial port works during shutdown
// RULE21: Shutdown reads return identification word
// RULE22: Read, shutdown, ID read, convert in one frame
// RULE23: Select rise clears counter, applies command
module tsh_host
    import tsh_pkg::*;
#(
    parameter int HALF = HALF_CYC,
    parameter int CONV = CONV_CYC
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 start,
    input  wire tsh_op_t              op,
    input  wire logic [4:0]           rd_bits,
    input  wire logic                 cmd_shutdown,
    output var  logic                 busy,
    output var  logic                 done,
    output var  logic [WORD_BITS-1:0] rd_word,
    output var  logic [WORD_BITS-1:0] id_word,
    output var  logic [TEMP_BITS-1:0] temp,
    output var  logic                 fill_ok,
    output var  logic                 mode_sd,
    output var  logic                 temp_valid,
    output var  logic                 cs_n,
    output wire logic                 sclk,
    input  wire logic                 sio_in,
    output var  logic                 sio_out,
    output var  logic                 sio_oe
);

    // ************************************************************
    // Decoding functions
    // ************************************************************
    // Bit k of the frame that the host writes; the command byte
    // fills both bytes so the ignored upper byte is harmless
    function automatic logic tx_bit(tsh_op_t o, logic sd,
                                    logic [6:0] k);
        logic [7:0] b;
        b = CMD_CONVERT;
        if (o == TSH_OP_IDSEQ) begin
            b = k[5] ? CMD_CONVERT : CMD_SHUTDOWN; // RULE22
        end else if (sd) begin
            b = CMD_SHUTDOWN; // RULE13
        end
        tx_bit = b[~k[2:0]]; // RULE14
    endfunction : tx_bit

    // Number of clocks in a frame of the given kind
    function automatic logic [6:0] frame_len(tsh_op_t o,
                                             logic [4:0] n);
        logic [6:0] len;
        len = 7'(WORD_BITS);
        case (o)
            TSH_OP_READ: begin
                if (n != 5'h00 && n < 5'(WORD_BITS)) begin
                    len = {2'h0, n}; // RULE8
                end
            end
            TSH_OP_RDWR: begin
                len = 7'(RDWR_BITS); // RULE4
            end
            TSH_OP_IDSEQ: begin
                len = 7'(IDSEQ_BITS); // RULE22
            end
            default: begin
                len = 7'(WORD_BITS); // RULE3
            end
        endcase
        frame_len = len;
    endfunction : frame_len

    // ************************************************************
    // Declarations
    // ************************************************************
    tsh_phase_if ph ();

    tsh_state_t           state;
    tsh_state_t           next_state;
    tsh_op_t              op_q;
    logic                 cmd_q;
    logic [5:0]           tmr;
    logic [6:0]           bits;
    logic [6:0]           total;
    logic [WORD_BITS-1:0] rx;
    logic                 sio_s1;
    logic                 sio_s2;
    logic [31:0]          conv_cnt;
    logic [5:0]           hi_cnt;
    logic [5:0]           lo_cnt;

    wire                  active_w;
    wire                  done_w;
    wire [6:0]            idx_w;
    wire [WORD_BITS-1:0]  next_rx;
    wire                  cap_w;
    wire [WORD_BITS-1:0]  cap_word_w;
    wire                  end_sd_w;
    wire                  restart_w;
    wire                  conv_full_w;

    // ************************************************************
    // Clock generator and input synchroniser
    // ************************************************************
    tsh_sclk_gen #(
        .HALF (HALF),
        .SDLY (SYNC_STAGES)
    ) u_gen (
        .clk (clk),
        .rst (rst),
        .ph  (ph)
    );

    assign sclk = ph.sclk;

    always_ff @(posedge clk) begin
        if (rst) begin
            sio_s1 <= 1'b0;
            sio_s2 <= 1'b0;
        end else begin
            sio_s1 <= sio_in;
            sio_s2 <= sio_s1;
        end
    end

    // ************************************************************
    // Frame sequencer
    // ************************************************************
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (tmr == 6'(SETUP_CYC - 1)) begin
                    next_state = ST_SHIFT; // RULE6
                end
            end
            ST_SHIFT: begin
                if (ph.rise && bits == total - 7'h01) begin
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (tmr == 6'(HOLD_CYC - 1)) begin
                    next_state = ST_GAP; // RULE2
                end
            end
            ST_GAP: begin
                if (tmr == 6'(GAP_CYC - 1)) begin
                    next_state = ST_IDLE; // RULE2
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    assign active_w = (next_state == ST_SETUP) ||
                      (next_state == ST_SHIFT) ||
                      (next_state == ST_HOLD);
    assign done_w   = (state == ST_HOLD) && (next_state == ST_GAP);

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
            tmr   <= 6'h00;
        end else begin
            state <= next_state;
            tmr   <= (next_state != state) ? 6'h00 : tmr + 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            op_q  <= TSH_OP_READ;
            cmd_q <= 1'b0;
            total <= 7'(WORD_BITS);
        end else if (state == ST_IDLE && start) begin
            op_q  <= op;
            cmd_q <= cmd_shutdown;
            total <= frame_len(op, rd_bits);
        end
    end

    // ************************************************************
    // Pin drivers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            cs_n   <= 1'b1;
            ph.run <= 1'b0;
            busy   <= 1'b0;
            done   <= 1'b0;
        end else begin
            cs_n   <= !active_w; // RULE2
            ph.run <= (next_state == ST_SHIFT) ||
                      (next_state == ST_HOLD);
            busy   <= (next_state != ST_IDLE);
            done   <= done_w;
        end
    end

    // Rising edges counted per frame; cleared while select is high
    always_ff @(posedge clk) begin
        if (rst || cs_n) begin
            bits <= 7'h00; // RULE23
        end else if (ph.rise) begin
            bits <= bits + 7'h01;
        end
    end

    // Write bits change only on a falling clock edge, and only in
    // the second half of each 32-clock segment
    always_ff @(posedge clk) begin
        if (rst || !active_w) begin
            sio_oe  <= 1'b0; // RULE5
            sio_out <= 1'b0;
        end else if (ph.fall) begin
            sio_oe  <= bits[4]; // RULE4
            sio_out <= bits[4] && tx_bit(op_q, cmd_q, bits); // RULE1
        end
    end

    // ************************************************************
    // Receive path
    // ************************************************************
    assign idx_w      = bits - 7'h01;
    assign next_rx    = {rx[WORD_BITS-2:0], sio_s2}; // RULE19
    assign cap_w      = ph.sample && !idx_w[4] &&
                        (idx_w[3:0] == 4'hF || idx_w == total - 7'h01);
    assign cap_word_w = next_rx << (4'hF - idx_w[3:0]); // RULE8

    // Bits are taken a fixed delay after each rise; RULE7 makes the
    // first bit already valid at that point
    always_ff @(posedge clk) begin
        if (rst) begin
            rx <= '0;
        end else if (ph.sample && !idx_w[4]) begin
            rx <= next_rx; // RULE1
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_word <= '0;
            id_word <= '0;
            temp    <= '0;
            fill_ok <= 1'b0;
        end else if (cap_w && !idx_w[5]) begin
            rd_word <= cap_word_w; // RULE10
            temp    <= cap_word_w[WORD_BITS-1:TEMP_LSB]; // RULE17
            fill_ok <= (cap_word_w[1:0] == FILL_BITS); // RULE18
        end else if (cap_w) begin
            id_word <= cap_word_w; // RULE21
        end
    end

    // ************************************************************
    // Mode tracking and conversion wait
    // ************************************************************
    assign end_sd_w    = (op_q == TSH_OP_IDSEQ) ? 1'b0 : cmd_q;
    assign restart_w   = done_w && (op_q != TSH_OP_READ) &&
                         (mode_sd || op_q == TSH_OP_IDSEQ) && !end_sd_w;
    assign conv_full_w = (conv_cnt == 32'(CONV));

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_sd <= 1'b0; // RULE15
        end else if (done_w && op_q != TSH_OP_READ) begin
            mode_sd <= end_sd_w; // RULE23
        end
    end

    // A fresh conversion time starts at reset and on leaving shutdown
    always_ff @(posedge clk) begin
        if (rst || restart_w) begin
            conv_cnt <= 32'h0000_0000; // RULE16
        end else if (!conv_full_w) begin
            conv_cnt <= conv_cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            temp_valid <= 1'b0;
        end else begin
            temp_valid <= conv_full_w && !mode_sd && !restart_w && // RULE16
                          !(done_w && end_sd_w);
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            hi_cnt <= 6'h00;
            lo_cnt <= 6'h00;
        end else begin
            hi_cnt <= !cs_n ? 6'h00 :
                      (hi_cnt == 6'h3F) ? hi_cnt : hi_cnt + 6'h01;
            lo_cnt <= cs_n ? 6'h00 :
                      (lo_cnt == 6'h3F) ? lo_cnt : lo_cnt + 6'h01;
        end
    end

    AST_CS_GAP: assert property ( // RULE2
        @(posedge clk) disable iff (rst)
        $fell(cs_n) |-> $past(hi_cnt) >= 6'(GAP_CYC))
        else $error("Select high gap too short");

    AST_CS_HOLD: assert property ( // RULE2
        @(posedge clk) disable iff (rst)
        $rose(cs_n) |-> sclk && $past(sclk, HOLD_CYC))
        else $error("Select rose without clock hold time");

    AST_SCLK_QUIET_AT_CS: assert property ( // RULE6
        @(posedge clk) disable iff (rst)
        $fell(cs_n) |-> !sclk ##1 !sclk [*8])
        else $error("Clock not quiet while select falls");

    AST_FIRST_RISE_SETUP: assert property ( // RULE7
        @(posedge clk) disable iff (rst)
        $rose(sclk) |-> lo_cnt >= 6'(SETUP_CYC))
        else $error("Clock rose too soon after select fell");

    AST_RELEASE_WHEN_HIGH: assert property ( // RULE5
        @(posedge clk) disable iff (rst)
        cs_n |-> !sio_oe)
        else $error("Data pin driven while select high");

    AST_DRIVE_ON_FALL: assert property ( // RULE1
        @(posedge clk) disable iff (rst)
        ($rose(sio_oe) || (sio_oe && $changed(sio_out)))
            |-> $past(ph.fall) && !sclk)
        else $error("Write data changed away from a falling edge");

    AST_TX_PHASE_ONLY: assert property ( // RULE4
        @(posedge clk) disable iff (rst)
        sio_oe |-> (bits[4] || bits[4:0] == 5'h00) && !cs_n)
        else $error("Host drove data in the sensor transmit phase");

    AST_READ_LEN: assert property ( // RULE3
        @(posedge clk) disable iff (rst)
        $rose(cs_n) && op_q == TSH_OP_READ |-> $past(bits) == total)
        else $error("Read frame clock count wrong");

    AST_MAX_LOW: assert property ( // RULE11
        @(posedge clk) disable iff (rst)
        !cs_n && op_q != TSH_OP_IDSEQ |-> bits <= 7'(RDWR_BITS))
        else $error("Select held low beyond 32 clocks");

    AST_IDSEQ_LEN: assert property ( // RULE22
        @(posedge clk) disable iff (rst)
        $rose(cs_n) && op_q == TSH_OP_IDSEQ
            |-> $past(bits) == 7'(IDSEQ_BITS))
        else $error("Identification frame clock count wrong");

    AST_CMD_BYTE: assert property ( // RULE14
        @(posedge clk) disable iff (rst)
        sio_oe |-> sio_out == tx_bit(op_q, cmd_q, idx_w))
        else $error("Host sent a command outside 00 and FF");

    AST_TEMP_WAIT: assert property ( // RULE16
        @(posedge clk) disable iff (rst)
        temp_valid |-> conv_cnt == 32'(CONV) && !mode_sd)
        else $error("Temperature flagged valid before conversion time");

endmodule : tsh_host
`default_nettype wire

// ==== logic/tsh_phase_if.sv ====
// Serial clock phase signals between controller and clock generator
`timescale 1ns/1ps
`default_nettype none
interface tsh_phase_if;
    logic run;
    logic sclk;
    logic rise;
    logic fall;
    logic sample;
    modport gen (input run, output sclk, output rise, output fall,
                 output sample);
    modport ctl (output run, input sclk, input rise, input fall,
                 input sample);
endinterface : tsh_phase_if
`default_nettype wire

// ==== logic/tsh_pkg.sv ====
// Constants and types for the temperature sensor host controller
package tsh_pkg;

    // ************************************************************
    // Timing figures, as printed, and their cycle counts
    // ************************************************************
    localparam int CLK_PERIOD_NS      = 5;
    localparam int SCLK_MIN_PERIOD_NS = 160;
    localparam int CS_SETUP_NS        = 100;
    localparam int CS_HOLD_NS         = 50;
    localparam int CS_GAP_NS          = 160;
    localparam int CONV_TIME_MS       = 228;
    localparam int SYNC_STAGES        = 2;

    // Least times round up to whole cycles
    localparam int HALF_CYC  =
        (SCLK_MIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC =
        (CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC  =
        (CS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CYC   =
        (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_CYC  =
        CONV_TIME_MS * 1_000_000 / CLK_PERIOD_NS;

    // ************************************************************
    // Frame layout and command codes
    // ************************************************************
    localparam int WORD_BITS   = 16;
    localparam int RDWR_BITS   = 32;
    localparam int IDSEQ_BITS  = 64;
    localparam int TEMP_LSB    = 2;
    localparam int TEMP_BITS   = 14;
    localparam logic [7:0] CMD_SHUTDOWN = 8'hFF;
    localparam logic [7:0] CMD_CONVERT  = 8'h00;
    localparam logic [1:0] FILL_BITS    = 2'h3;

    typedef enum logic [1:0] {
        TSH_OP_READ  = 2'h0,
        TSH_OP_RDWR  = 2'h1,
        TSH_OP_IDSEQ = 2'h2
    } tsh_op_t;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_SETUP = 5'h02,
        ST_SHIFT = 5'h04,
        ST_HOLD  = 5'h08,
        ST_GAP   = 5'h10
    } tsh_state_t;

endpackage : tsh_pkg

// ==== logic/tsh_sclk_gen.sv ====
// Serial shift clock divider with edge and sample strobes
`timescale 1ns/1ps
`default_nettype none
module tsh_sclk_gen
    import tsh_pkg::*;
#(
    parameter int HALF = HALF_CYC,
    parameter int SDLY = SYNC_STAGES
) (
    input wire logic clk,
    input wire logic rst,
    tsh_phase_if.gen ph
);
    logic [7:0]      cnt;
    logic [SDLY-1:0] dly;
    wire             last_w = (cnt == 8'(HALF - 1));

    // ************************************************************
    // Divider: clock idles low, first rise one half period after run
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst || !ph.run) begin
            cnt     <= 8'h00;
            ph.sclk <= 1'b0;
            ph.rise <= 1'b0;
            ph.fall <= 1'b0;
        end else begin
            cnt     <= last_w ? 8'h00 : cnt + 8'h01;
            ph.sclk <= last_w ? !ph.sclk : ph.sclk;
            ph.rise <= last_w && !ph.sclk;
            ph.fall <= last_w && ph.sclk;
        end
    end

    // Sample strobe trails the rise by the input synchroniser depth
    always_ff @(posedge clk) begin
        if (rst) begin
            dly <= '0;
        end else begin
            dly <= {dly[SDLY-2:0], ph.rise};
        end
    end

    assign ph.sample = dly[SDLY-1];

endmodule : tsh_sclk_gen
`default_nettype wire

// ==== tb/tsh_host_tb_top.sv ====
// Self-checking bench for the sensor host controller
`timescale 1ns/1ps
`default_nettype none
`define TSH_CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
    fails++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tsh_host_tb_top
    import tsh_pkg::*;
;
    localparam logic [15:0] ID_W = 16'h5A3F;  // Arbitrary value
    typedef struct packed {
        tsh_op_t     op;
        logic        sd;
        logic [15:0] w_in;
        logic [15:0] w_exp;
        logic        m_exp;
    } tsh_row_t;
    tsh_row_t rows [10] = '{
        '{TSH_OP_READ, 1'h0, 16'h4B03, 16'h4B03, 1'h0},
        '{TSH_OP_RDWR, 1'h0, 16'h3E83, 16'h3E83, 1'h0},
        '{TSH_OP_READ, 1'h0, 16'h0C83, 16'h0C83, 1'h0},
        '{TSH_OP_RDWR, 1'h1, 16'h0007, 16'h0007, 1'h1},
        '{TSH_OP_READ, 1'h0, 16'h0003, ID_W,     1'h1},
        '{TSH_OP_RDWR, 1'h0, 16'h0003, ID_W,     1'h0},
        '{TSH_OP_READ, 1'h0, 16'h0003, 16'h0003, 1'h0},
        '{TSH_OP_READ, 1'h0, 16'hFFFF, 16'hFFFF, 1'h0},
        '{TSH_OP_RDWR, 1'h0, 16'hF383, 16'hF383, 1'h0},
        '{TSH_OP_READ, 1'h0, 16'hEC03, 16'hEC03, 1'h0}
    };
    logic        clk     = 1'h0;
    logic        rst     = 1'h1;
    logic        start   = 1'h0;
    tsh_op_t     op      = TSH_OP_READ;
    logic [4:0]  rd_bits = 5'h00;
    logic        cmd_sd  = 1'h0;
    logic [13:0] t_code  = 14'h0000;
    logic        flip    = 1'h0;
    logic        busy, done, fill_ok, mode_sd, temp_valid, cs_n;
    logic        sio_out, sio_oe, dev_out, dev_oe, dev_sd;
    logic [15:0] rd_word, id_word;
    logic [13:0] temp;
    logic [7:0]  viol_cnt;
    wire logic   sclk;
    wire logic   sio;
    int          fails  = 0;
    int          checks = 0;
    int          k;
    int          n;

    // Released pin shows a changing pattern, never the last value
    assign sio = sio_oe ? sio_out : (dev_oe ? dev_out : flip);
    always #2.5 clk = ~clk;
    always @(posedge clk) flip <= ~flip;

    tsh_host #(.HALF(16), .CONV(200)) tsh_host_inst (
        .clk(clk), .rst(rst), .start(start), .op(op), .rd_bits(rd_bits),
        .cmd_shutdown(cmd_sd), .busy(busy), .done(done),
        .rd_word(rd_word), .id_word(id_word), .temp(temp),
        .fill_ok(fill_ok), .mode_sd(mode_sd), .temp_valid(temp_valid),
        .cs_n(cs_n), .sclk(sclk), .sio_in(sio), .sio_out(sio_out),
        .sio_oe(sio_oe));

    tsh_sensor_model #(.CONV(150), .ID_WORD(ID_W)) tsh_sensor_model_inst (
        .clk(clk), .cs_n(cs_n), .sclk(sclk), .sio(sio),
        .host_out(sio_out), .host_oe(sio_oe), .temp_code(t_code),
        .dev_out(dev_out), .dev_oe(dev_oe), .dev_sd(dev_sd),
        .viol_cnt(viol_cnt));

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic report_and_stop();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    task automatic time_out();
        fails++;
        $display("[FAIL] wait expected 1 seen 0");
        report_and_stop();
    endtask : time_out

    task automatic run_op(input tsh_op_t o, input logic [4:0] b,
                          input logic s);
        int i;
        @(posedge clk);
        op      <= o;
        rd_bits <= b;
        cmd_sd  <= s;
        start   <= 1'h1;
        @(posedge clk);
        start <= 1'h0;
        for (i = 0; i < 5000 && done !== 1'h1; i++) begin
            @(posedge clk);
            #1;
        end
        if (done !== 1'h1) time_out();
        for (i = 0; i < 100 && busy !== 1'h0; i++) begin
            @(posedge clk);
            #1;
        end
        if (busy !== 1'h0) time_out();
    endtask : run_op

    task automatic wait_valid();
        int i;
        for (i = 0; i < 1000 && temp_valid !== 1'h1; i++) begin
            @(posedge clk);
            #1;
        end
        if (temp_valid !== 1'h1) time_out();
    endtask : wait_valid

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        #1;
        `TSH_CHK("cs_n", 1'h1, cs_n);
        `TSH_CHK("sio_oe", 1'h0, sio_oe);
        `TSH_CHK("mode_sd", 1'h0, mode_sd);
        repeat (150) @(posedge clk);
        #1;
        `TSH_CHK("temp_valid", 1'h0, temp_valid);
        wait_valid();
        for (k = 0; k < 10; k++) begin
            @(posedge clk);
            t_code <= rows[k].w_in[15:2];
            repeat (200) @(posedge clk);
            run_op(rows[k].op, 5'h00, rows[k].sd);
            `TSH_CHK("rd_word", rows[k].w_exp, rd_word);
            `TSH_CHK("temp", rows[k].w_exp[15:2], temp);
            `TSH_CHK("fill_ok", 1'h1, fill_ok);
            `TSH_CHK("mode_sd", rows[k].m_exp, mode_sd);
            `TSH_CHK("dev_sd", rows[k].m_exp, dev_sd);
        end
        // Short reads keep only the leading bits
        for (n = 1; n < 16; n += 7) begin
            run_op(TSH_OP_READ, n[4:0], 1'h0);
            `TSH_CHK("rd_short", 16'hEC03 & ~(16'hFFFF >> n), rd_word);
        end
        run_op(TSH_OP_READ, 5'h10, 1'h0);
        `TSH_CHK("rd_full", 16'hEC03, rd_word);
        // New result appears only after a completed read
        @(posedge clk);
        t_code <= 14'h0320;
        run_op(TSH_OP_READ, 5'h00, 1'h0);
        `TSH_CHK("rd_old", 16'hEC03, rd_word);
        run_op(TSH_OP_READ, 5'h00, 1'h0);
        `TSH_CHK("rd_new", 16'h0C83, rd_word);
        run_op(TSH_OP_IDSEQ, 5'h00, 1'h0);
        `TSH_CHK("seq_temp", 16'h0C83, rd_word);
        `TSH_CHK("seq_id", ID_W, id_word);
        `TSH_CHK("seq_mode", 1'h0, dev_sd);
        `TSH_CHK("seq_valid", 1'h0, temp_valid);
        wait_valid();
        // Reset in the middle of a frame
        @(posedge clk);
        start <= 1'h1;
        @(posedge clk);
        start <= 1'h0;
        repeat (80) @(posedge clk);
        rst <= 1'h1;
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        #1;
        `TSH_CHK("rst_cs_n", 1'h1, cs_n);
        `TSH_CHK("rst_busy", 1'h0, busy);
        `TSH_CHK("rst_valid", 1'h0, temp_valid);
        wait_valid();
        run_op(TSH_OP_READ, 5'h00, 1'h0);
        `TSH_CHK("rd_after", 16'h0C83, rd_word);
        `TSH_CHK("viol_cnt", 8'h00, viol_cnt);
        report_and_stop();
    end
endmodule : tsh_host_tb_top
`default_nettype wire

// ==== tb/tsh_sensor_model.sv ====
// Behavioural model of the serial temperature sensor at the far end
`timescale 1ns/1ps
`default_nettype none
module tsh_sensor_model
    import tsh_pkg::*;
#(
    parameter int          CONV    = 150,
    parameter logic [15:0] ID_WORD = 16'h5A3F  // Arbitrary value
) (
    input  wire logic        clk,
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic        sio,
    input  wire logic        host_out,
    input  wire logic        host_oe,
    input  wire logic [13:0] temp_code,
    output var  logic        dev_out,
    output var  logic        dev_oe,
    output var  logic        dev_sd,
    output var  logic [7:0]  viol_cnt
);
    // ************************************************************
    // State
    // ************************************************************
    logic [15:0] result   = 16'h0000;  // Invalid until first conversion
    logic [15:0] out_reg  = 16'h0000;
    logic [15:0] word;
    logic [7:0]  rx;
    logic        cs_q     = 1'h1;
    int          r        = 0;
    int          rx_n     = 0;
    int          conv_cnt = 0;
    realtime     t_fall_cs;
    realtime     t_rise;
    realtime     t_dat;
    realtime     t_rise_cs = -1000.0;

    initial begin
        dev_out  = 1'h0;
        dev_oe   = 1'h0;
        dev_sd   = 1'h0;
        viol_cnt = 8'h00;
    end

    task automatic flag();
        viol_cnt = viol_cnt + 8'h01;
    endtask : flag

    task automatic apply(input logic [7:0] c);
        if (c == CMD_SHUTDOWN) dev_sd = 1'h1;
        else if (c == CMD_CONVERT) dev_sd = 1'h0;
        else flag();
    endtask : apply

    // ************************************************************
    // Conversion timebase
    // ************************************************************
    always @(posedge clk) begin
        cs_q <= cs_n;
        if (dev_sd || (cs_n && !cs_q)) conv_cnt <= 0;
        else if (conv_cnt == CONV - 1) begin
            conv_cnt <= 0;
            result   <= {temp_code, FILL_BITS};
        end else conv_cnt <= conv_cnt + 1;
        if (cs_n) out_reg <= result;
    end

    always @(negedge clk) begin
        if (host_oe && dev_oe) flag();
    end

    // ************************************************************
    // Serial port
    // ************************************************************
    always @(negedge cs_n) begin
        if (sclk !== 1'h0) flag();
        if ($realtime - t_rise_cs < 159.9) flag();
        word      = dev_sd ? ID_WORD : out_reg;
        r         = 0;
        rx_n      = 0;
        t_fall_cs = $realtime;
        dev_out   = word[15];
        dev_oe    = 1'h1;
    end

    always @(posedge sclk) begin
        if (cs_n === 1'h0) begin
            if (r > 0 && $realtime - t_rise < 159.9) flag();
            if ($realtime - t_fall_cs < 100.0) flag();
            if (host_oe && $realtime - t_dat < 30.0) flag();
            if (r % 32 >= 16) begin
                rx   = {rx[6:0], sio};
                rx_n = rx_n + 1;
            end
            if (r % 32 == 31) apply(rx);
            r      = r + 1;
            t_rise = $realtime;
        end
    end

    always @(negedge sclk) begin
        if (cs_n === 1'h0) begin
            if (r % 32 < 16) begin
                if (r % 32 == 0) #10;  // Output delay lets the host let go
                if (r % 32 == 0) word = dev_sd ? ID_WORD : out_reg;
                dev_out = word[15 - r % 32];
                dev_oe  = 1'h1;
            end else begin
                dev_oe = 1'h0;
                if (r % 32 == 16) rx_n = 0;
            end
        end
    end

    always @(posedge cs_n) begin
        dev_oe = 1'h0;
        if (rx_n >= 8 && r % 32 != 0) apply(rx);
        if (r > 0 && $realtime - t_rise < 50.0) flag();
        if (r > 32 && r != 64) flag();
        rx_n      = 0;
        t_rise_cs = $realtime;
    end

    always @(host_out) begin
        if (host_oe && $realtime - t_rise < 50.0) flag();
        t_dat = $realtime;
    end
endmodule : tsh_sensor_model
`default_nettype wire
